// ### rtl/shra_pkg.sv
// Constants, types and behaviour summary for the serial host port and alert logic
// How it works
// - Enabled events drive the active-low alert pin low; otherwise it stays high.
// - Alert pulse mode picks a timed low pulse or a hold until the flags are read.
// - Alert is the OR of all sources enabled in the command register at 0x08.
// - Eight sources: error pin, input activity, rate, status, audio pin, burst, slip, emphasis.
// - Flags latch into read bits 8 to 15 of 0xEA; sources 0 and 4 read live pins.
// - In hold mode the alert releases as soon as address 0xEA is accepted.
// - In pulse mode each event gives a low pulse of half to one sample.
// - Serial output is three-state, never open-drain.
// - Six bus addresses 0xE8 to 0xED decode, sent high nibble first, LSB first.
// - First chip address bit is the low one, the second the high one.
// - Serial output drives from frame enable rise after a read address until its fall.
// - Output disable bit keeps the serial output high-impedance at all times.
// - Alert pulse mode bit: 0 holds low while pending (default), 1 pulses.
// - Output disable bit: 0 lets the output drive (default), 1 keeps it off.
// - Soft reset bit clears the flags and alert pulse state but never the command registers.
`default_nettype none
package shra_pkg;
    // ==========================================================
    // Bus addresses
    localparam logic [7:0] BA_FUNC_WR  = 8'he8;
    localparam logic [7:0] BA_CS_WR    = 8'he9;
    localparam logic [7:0] BA_INT_RD   = 8'hea;
    localparam logic [7:0] BA_FS_RD    = 8'heb;
    localparam logic [7:0] BA_CS_RD    = 8'hec;
    localparam logic [7:0] BA_BURST_RD = 8'hed;
    // ==========================================================
    // Command register offsets
    localparam int NUM_CMD = 12;
    localparam logic [3:0] CMD_GLOBAL    = 4'h0;
    localparam logic [3:0] CMD_RX_SYS    = 4'h1;
    localparam logic [3:0] CMD_MCLK      = 4'h2;
    localparam logic [3:0] CMD_PRI_CLK   = 4'h3;
    localparam logic [3:0] CMD_SEC_CLK   = 4'h4;
    localparam logic [3:0] CMD_SRC_SEL   = 4'h5;
    localparam logic [3:0] CMD_ROUTING   = 4'h6;
    localparam logic [3:0] CMD_OUT_FMT   = 4'h7;
    localparam logic [3:0] CMD_ALERT_EN  = 4'h8;
    localparam logic [3:0] CMD_ERR_CFG   = 4'h9;
    localparam logic [3:0] CMD_TX_SYS    = 4'ha;
    localparam logic [3:0] CMD_TX_DATA   = 4'hb;
    localparam logic [3:0] CMD_TEST_A    = 4'hc;
    localparam logic [3:0] CMD_TEST_B    = 4'hd;
    localparam logic [3:0] CMD_TEST_C    = 4'he;
    localparam logic [3:0] CMD_TEST_D    = 4'hf;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    // ==========================================================
    // Field positions
    localparam int GSC_SOFT_RESET_BIT  = 0;
    localparam int GSC_OUT_DISABLE_BIT = 1;
    localparam int GSC_ALERT_PULSE_BIT = 3;
    localparam int DI_CHIP_LOW  = 0;
    localparam int DI_CHIP_HIGH = 1;
    localparam int DI_CMD_LSB   = 4;
    localparam int DI_DATA_LSB  = 8;
    localparam int DO_FLAG_LSB  = 8;
    localparam int FRAME_BITS   = 16;
    localparam int SRC_ERROR = 0;
    localparam int SRC_AUDIO = 4;
    // ==========================================================
    // Alert pulse width, in half sample periods and in 2fs ticks
    localparam int ALERT_PULSE_MIN_HALF_FS = 1;
    localparam int ALERT_PULSE_MAX_HALF_FS = 3;
    localparam int ALERT_PULSE_TICKS = ALERT_PULSE_MIN_HALF_FS + 1;
    // ==========================================================
    // Types
    typedef struct packed {
        logic emphasis_change_src;
        logic slave_slip_src;
        logic burst_info_renew_src;
        logic chan_status_renew_src;
        logic rate_change_src;
        logic input_activity_src;
    } shra_evt_t;
    typedef struct packed {
        logic serial_clock;
        logic chip_enable;
        logic serial_in;
        logic receive_error_pin;
        logic audio_pin;
        logic chip_addr_low;
        logic chip_addr_high;
    } shra_link_t;
    typedef enum logic [1:0] {
        RSEL_INT   = 2'h0,
        RSEL_FS    = 2'h1,
        RSEL_CS    = 2'h2,
        RSEL_BURST = 2'h3
    } shra_rsel_t;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LOAD = 5'h02,
        ST_WR   = 5'h04,
        ST_RD   = 5'h08,
        ST_SKIP = 5'h10
    } shra_state_t;
endpackage
`default_nettype wire

// ### rtl/shra_sync.sv
// Two-flop synchroniser for pins entering the clk domain
`default_nettype none
module shra_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    if (W < 1) begin : g_bad_w
        $error("shra_sync: W must be at least 1");
    end

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/shra_alert.sv
// Alert pin driver: hold-until-read or timed low pulse
`default_nettype none
module shra_alert #(
    parameter int PULSE_TICKS = shra_pkg::ALERT_PULSE_TICKS
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic flush,
    input  wire logic pulse_mode,
    input  wire logic fire,
    input  wire logic pending_any,
    input  wire logic tick_2fs,
    output logic      alert_n
);
    import shra_pkg::*;
    localparam logic [1:0] LOAD_CNT = 2'(PULSE_TICKS);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       alert_n_nxt;

    if (PULSE_TICKS < 2 || PULSE_TICKS > 3) begin : g_bad_ticks
        $error("shra_alert: PULSE_TICKS out of range");
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (flush || !pulse_mode) begin
            cnt_nxt = 2'h0;
        end else if (fire) begin
            cnt_nxt = LOAD_CNT;
        end else if (tick_2fs && cnt_r != 2'h0) begin
            cnt_nxt = cnt_r - 2'h1;
        end
        if (flush) begin
            alert_n_nxt = 1'b1;
        end else if (pulse_mode) begin
            alert_n_nxt = (cnt_nxt == 2'h0);
        end else begin
            alert_n_nxt = !pending_any;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 2'h0;
            alert_n <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            alert_n <= alert_n_nxt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/shra_regs.sv
// Serial host port: address decode, command registers, flag readout, alert
`default_nettype none
module shra_regs (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire shra_pkg::shra_link_t    link_pins,
    input  wire shra_pkg::shra_evt_t     events,
    input  wire logic                    rate_tick_2fs,
    input  wire logic [15:0]             ext_rd_data,
    output logic                         serial_out,
    output logic                         serial_out_oe_n,
    output logic                         alert_n,
    output shra_pkg::shra_rsel_t         rd_sel,
    output logic [7:0]                   cs_byte,
    output logic                         cs_byte_stb,
    output logic [11:0][7:0]             cfg
);
    import shra_pkg::*;

    // ==========================================================
    // Elaboration checks
    if (NUM_CMD <= int'(CMD_ALERT_EN) || NUM_CMD > 12) begin : g_bad_num_cmd
        $error("shra_regs: NUM_CMD must reach the source enables and fit cfg");
    end
    if (FRAME_BITS != 16 || DO_FLAG_LSB + 8 > FRAME_BITS) begin : g_bad_frame
        $error("shra_regs: frame layout must fit the 16-bit shift registers");
    end

    // ==========================================================
    // Pin synchronisers and edge detection
    shra_link_t  pin_s;
    shra_link_t  pin_d_r;
    shra_link_t  pin_d_nxt;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        ce_rise;
    logic        ce_fall;
    logic        receive_error_pin_chg;
    logic        audio_chg;

    shra_sync #(
        .W($bits(shra_link_t))
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (link_pins),
        .q      (pin_s)
    );

    always_comb begin
        pin_d_nxt = pin_s;
        sclk_rise = pin_s.serial_clock & ~pin_d_r.serial_clock;
        sclk_fall = ~pin_s.serial_clock & pin_d_r.serial_clock;
        ce_rise = pin_s.chip_enable & ~pin_d_r.chip_enable;
        ce_fall = ~pin_s.chip_enable & pin_d_r.chip_enable;
        receive_error_pin_chg = pin_s.receive_error_pin ^ pin_d_r.receive_error_pin;
        audio_chg = pin_s.audio_pin ^ pin_d_r.audio_pin;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_d_r <= '0;
        end else begin
            pin_d_r <= pin_d_nxt;
        end
    end

    // ==========================================================
    // Command register controls
    logic soft_rst;
    logic out_dis;
    logic pulse_mode;

    always_comb begin
        soft_rst = cfg[CMD_GLOBAL][GSC_SOFT_RESET_BIT];
        out_dis = cfg[CMD_GLOBAL][GSC_OUT_DISABLE_BIT];
        pulse_mode = cfg[CMD_GLOBAL][GSC_ALERT_PULSE_BIT];
    end

    // ==========================================================
    // Interrupt sources and flags
    logic [7:0]  src;
    logic [7:0]  fire_v;
    logic [7:0]  flag_r;
    logic [7:0]  flag_nxt;
    logic [15:0] flag_word;
    logic        clr_flags;

    always_comb begin
        src = {events.emphasis_change_src,
               events.slave_slip_src,
               events.burst_info_renew_src,
               audio_chg,
               events.chan_status_renew_src,
               events.rate_change_src,
               events.input_activity_src,
               receive_error_pin_chg};
        fire_v = src & cfg[CMD_ALERT_EN];
        if (soft_rst) begin
            flag_nxt = 8'h00;
        end else begin
            flag_nxt = (flag_r & ~{8{clr_flags}}) | fire_v;
        end
        flag_word = 16'h0000;
        flag_word[DO_FLAG_LSB +: 8] = flag_r;
        flag_word[DO_FLAG_LSB + SRC_ERROR] = pin_s.receive_error_pin;
        flag_word[DO_FLAG_LSB + SRC_AUDIO] = pin_s.audio_pin;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_r <= 8'h00;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    shra_alert #(
        .PULSE_TICKS(ALERT_PULSE_TICKS)
    ) u_alert (
        .clk         (clk),
        .resetn      (resetn),
        .flush       (soft_rst),
        .pulse_mode  (pulse_mode),
        .fire        (|fire_v),
        .pending_any (|(flag_r & cfg[CMD_ALERT_EN])),
        .tick_2fs    (rate_tick_2fs),
        .alert_n     (alert_n)
    );

    // ==========================================================
    // Serial frame engine
    shra_state_t st_r;
    shra_state_t st_nxt;
    logic [15:0] in_sr_r;
    logic [15:0] in_sr_nxt;
    logic [4:0]  bit_cnt_r;
    logic [4:0]  bit_cnt_nxt;
    logic [7:0]  addr_r;
    logic [7:0]  addr_nxt;
    logic [7:0]  addr_in;
    logic [15:0] out_sr_r;
    logic [15:0] out_sr_nxt;
    logic [15:0] load_word;
    logic        seen_r;
    logic        seen_nxt;
    logic        so_nxt;
    logic        oe_n_nxt;
    shra_rsel_t  rd_sel_nxt;
    logic [7:0]  cs_byte_nxt;
    logic        cs_stb_nxt;
    logic [11:0][7:0] cfg_nxt;
    logic [3:0]  cmd_in;
    logic        chip_hit;

    always_comb begin
        // Address arrives A0..A3 (upper nibble) then B0..B3, LSB first
        addr_in = {in_sr_r[11:8], in_sr_r[15:12]};
        cmd_in = in_sr_r[DI_CMD_LSB +: 4];
        chip_hit = (in_sr_r[DI_CHIP_LOW] == pin_s.chip_addr_low) &&
                   (in_sr_r[DI_CHIP_HIGH] == pin_s.chip_addr_high);
        load_word = (rd_sel == RSEL_INT) ? flag_word : ext_rd_data;
        st_nxt = st_r;
        in_sr_nxt = in_sr_r;
        bit_cnt_nxt = bit_cnt_r;
        addr_nxt = addr_r;
        out_sr_nxt = out_sr_r;
        seen_nxt = seen_r;
        so_nxt = serial_out;
        oe_n_nxt = serial_out_oe_n;
        rd_sel_nxt = rd_sel;
        cs_byte_nxt = cs_byte;
        cs_stb_nxt = 1'b0;
        cfg_nxt = cfg;
        clr_flags = 1'b0;
        if (sclk_rise) begin
            in_sr_nxt = {pin_s.serial_in, in_sr_r[15:1]};
            if (bit_cnt_r != 5'h1f) begin
                bit_cnt_nxt = bit_cnt_r + 5'h01;
            end
        end
        case (st_r)
            ST_IDLE: begin
                oe_n_nxt = 1'b1;
                if (ce_rise) begin
                    addr_nxt = addr_in;
                    bit_cnt_nxt = 5'h00;
                    seen_nxt = 1'b0;
                    case (addr_in)
                        BA_FUNC_WR, BA_CS_WR: begin
                            st_nxt = ST_WR;
                        end
                        BA_INT_RD: begin
                            rd_sel_nxt = RSEL_INT;
                            st_nxt = ST_LOAD;
                        end
                        BA_FS_RD: begin
                            rd_sel_nxt = RSEL_FS;
                            st_nxt = ST_LOAD;
                        end
                        BA_CS_RD: begin
                            rd_sel_nxt = RSEL_CS;
                            st_nxt = ST_LOAD;
                        end
                        BA_BURST_RD: begin
                            rd_sel_nxt = RSEL_BURST;
                            st_nxt = ST_LOAD;
                        end
                        default: begin
                            st_nxt = ST_SKIP;
                        end
                    endcase
                end
            end
            ST_LOAD: begin
                out_sr_nxt = {1'b0, load_word[15:1]};
                so_nxt = load_word[0];
                oe_n_nxt = 1'b0;
                clr_flags = (rd_sel == RSEL_INT);
                st_nxt = ST_RD;
                if (ce_fall) begin
                    oe_n_nxt = 1'b1;
                    bit_cnt_nxt = 5'h00;
                    st_nxt = ST_IDLE;
                end
            end
            ST_RD: begin
                if (sclk_rise) begin
                    seen_nxt = 1'b1;
                end
                // A fall before any rise is the idle-high clock leaving idle
                if (sclk_fall && seen_r) begin
                    so_nxt = out_sr_r[0];
                    out_sr_nxt = {1'b0, out_sr_r[15:1]};
                end
                if (ce_fall) begin
                    oe_n_nxt = 1'b1;
                    bit_cnt_nxt = 5'h00;
                    st_nxt = ST_IDLE;
                end
            end
            ST_WR: begin
                if (addr_r == BA_CS_WR && sclk_rise && bit_cnt_r[2:0] == 3'h7) begin
                    cs_byte_nxt = {pin_s.serial_in, in_sr_r[15:9]};
                    cs_stb_nxt = 1'b1;
                end
                if (ce_fall) begin
                    if (addr_r == BA_FUNC_WR && bit_cnt_r == 5'(FRAME_BITS) && chip_hit &&
                        cmd_in < 4'(NUM_CMD)) begin
                        cfg_nxt[cmd_in] = in_sr_r[DI_DATA_LSB +: 8];
                    end
                    bit_cnt_nxt = 5'h00;
                    st_nxt = ST_IDLE;
                end
            end
            ST_SKIP: begin
                if (ce_fall) begin
                    bit_cnt_nxt = 5'h00;
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                oe_n_nxt = 1'b1;
                bit_cnt_nxt = 5'h00;
                st_nxt = ST_IDLE;
            end
        endcase
        if (out_dis) begin
            oe_n_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= ST_IDLE;
            in_sr_r <= 16'h0000;
            bit_cnt_r <= 5'h00;
            addr_r <= 8'h00;
            out_sr_r <= 16'h0000;
            seen_r <= 1'b0;
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
            rd_sel <= RSEL_INT;
            cs_byte <= 8'h00;
            cs_byte_stb <= 1'b0;
            cfg <= {NUM_CMD{CFG_RESET}};
        end else begin
            st_r <= st_nxt;
            in_sr_r <= in_sr_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            addr_r <= addr_nxt;
            out_sr_r <= out_sr_nxt;
            seen_r <= seen_nxt;
            serial_out <= so_nxt;
            serial_out_oe_n <= oe_n_nxt;
            rd_sel <= rd_sel_nxt;
            cs_byte <= cs_byte_nxt;
            cs_byte_stb <= cs_stb_nxt;
            cfg <= cfg_nxt;
        end
    end
endmodule
`default_nettype wire

// ### dv/shra_regs_checker.sv
// Assertion checker for the serial host port and alert pin
`default_nettype none
module shra_regs_checker (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire shra_pkg::shra_link_t link_pins,
    input wire shra_pkg::shra_evt_t  events,
    input wire logic                 rate_tick_2fs,
    input wire logic [15:0]          ext_rd_data,
    input wire logic                 serial_out,
    input wire logic                 serial_out_oe_n,
    input wire logic                 alert_n,
    input wire shra_pkg::shra_rsel_t rd_sel,
    input wire logic [7:0]           cs_byte,
    input wire logic                 cs_byte_stb,
    input wire logic [11:0][7:0]     cfg
);
    import shra_pkg::*;
    logic       pls;
    logic       srst;
    logic [5:0] hit;
    logic [2:0] tk_r;
    logic [2:0] tk_nxt;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);
    assign pls = cfg[CMD_GLOBAL][GSC_ALERT_PULSE_BIT];
    assign srst = cfg[CMD_GLOBAL][GSC_SOFT_RESET_BIT];
    assign hit = {cfg[CMD_ALERT_EN][7:5], cfg[CMD_ALERT_EN][3:1]} & events & {6{!srst}};
    // ==========================================================
    // Ticks of 2fs counted while the alert pin is low
    always_comb begin
        tk_nxt = alert_n ? 3'h0 : tk_r + {2'h0, rate_tick_2fs && tk_r != 3'h7};
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) tk_r <= 3'h0;
        else tk_r <= tk_nxt;
    end
    // ==========================================================
    // Properties
    a_oe_ce_low: assert property (!link_pins.chip_enable [*6] |-> serial_out_oe_n)
        else $error("serial output driven with frame enable low");
    a_oe_after_ce: assert property ($fell(serial_out_oe_n) |->
        link_pins.chip_enable && $past(link_pins.chip_enable, 3))
        else $error("serial output driven before frame enable rose");
    a_disable_hiz: assert property (cfg[CMD_GLOBAL][GSC_OUT_DISABLE_BIT] &&
        $past(cfg[CMD_GLOBAL][GSC_OUT_DISABLE_BIT]) |-> serial_out_oe_n)
        else $error("serial output driven while disabled");
    a_alert_needs_en: assert property ($fell(alert_n) |->
        $past(cfg[CMD_ALERT_EN], 2) != 8'h00)
        else $error("alert fell with no source enabled");
    a_hold_latch: assert property (!pls && |hit |-> ##2 !alert_n)
        else $error("alert not low two cycles after enabled event");
    a_pulse_start: assert property (pls && |hit |-> ##1 !alert_n)
        else $error("alert pulse did not start one cycle after event");
    a_pulse_width: assert property (pls && $rose(alert_n) |-> tk_r == 3'h2)
        else $error("alert pulse did not end on second 2fs tick");
    a_read_release: assert property ($fell(serial_out_oe_n) && rd_sel == RSEL_INT &&
        !pls |-> ##[0:1] alert_n)
        else $error("alert not released on flag read");
    a_cfg_on_write: assert property ($changed(cfg) |->
        !link_pins.chip_enable && $past(link_pins.chip_enable, 8))
        else $error("command register changed outside a frame end");
endmodule
bind shra_regs shra_regs_checker u_chk (
    .clk(clk), .resetn(resetn), .link_pins(link_pins), .events(events),
    .rate_tick_2fs(rate_tick_2fs), .ext_rd_data(ext_rd_data), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .alert_n(alert_n), .rd_sel(rd_sel),
    .cs_byte(cs_byte), .cs_byte_stb(cs_byte_stb), .cfg(cfg)
);
`default_nettype wire

// ### dv/shra_host_model.sv
// Host controller model for the three-wire serial control bus
`default_nettype none
module shra_host_model
    import shra_pkg::*;
(
    output logic      serial_clock,
    output logic      chip_enable,
    output logic      serial_in,
    input  wire logic serial_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic idle_hi = 1'b0;
    initial begin
        serial_clock = 1'b0;
        chip_enable = 1'b0;
        serial_in = 1'b0;
    end
    // Data moves with the clock low, read bit taken just before the rise
    task automatic bit_io(input logic b, output logic s);
        serial_clock <= 1'b0;
        serial_in <= b;
        #32;
        s = serial_data;
        serial_clock <= 1'b1;
        #32;
    endtask
    task automatic xfer(input logic [7:0] a, input logic [15:0] wd, output logic [15:0] rd);
        logic s;
        chip_enable <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bit_io(a[(i + 4) % 8], s);
        end
        serial_clock <= idle_hi;
        #32;
        chip_enable <= 1'b1;
        #64;
        for (int i = 0; i < 16; i++) begin
            bit_io(wd[i], rd[i]);
        end
        serial_clock <= idle_hi;
        #32;
        chip_enable <= 1'b0;
        #64;
    endtask
    task automatic wr(input logic [3:0] cmd, input logic [7:0] d, input logic [1:0] chip);
        logic [15:0] rd;
        if (cmd < 4'hc) begin
            xfer(BA_FUNC_WR, {d, cmd, 2'h0, chip}, rd);
        end
    endtask
endmodule
`default_nettype wire

// ### dv/shra_regs_tb.sv
// Self-checking bench for the serial host port and alert pin
`default_nettype none
module shra_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import shra_pkg::*;
    localparam int         TP = 40;
    localparam logic [1:0] CHIP = 2'h1;
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic             sclk;
    logic             ce;
    logic             sdi;
    logic             err_pin = 1'b0;
    logic             aud_pin = 1'b1;
    shra_evt_t        events = '0;
    logic             tick = 1'b0;
    logic [5:0]       tcnt = 6'h00;
    logic [15:0]      rd_word = 16'h0000;
    logic             so;
    logic             oe_n;
    logic             alert_n;
    shra_rsel_t       rd_sel;
    logic [7:0]       cs_byte;
    logic             stb;
    logic [11:0][7:0] cfg;
    wire              sdo;
    int               err_total = 0;
    int               checks = 0;
    int               stb_n = 0;
    assign sdo = oe_n ? 1'bz : so;
    shra_regs dut (
        .clk(clk), .resetn(resetn), .events(events), .rate_tick_2fs(tick),
        .link_pins({sclk, ce, sdi, err_pin, aud_pin, CHIP[0], CHIP[1]}),
        .ext_rd_data(rd_word), .serial_out(so), .serial_out_oe_n(oe_n), .alert_n(alert_n),
        .rd_sel(rd_sel), .cs_byte(cs_byte), .cs_byte_stb(stb), .cfg(cfg)
    );
    shra_host_model host (
        .serial_clock(sclk), .chip_enable(ce), .serial_in(sdi), .serial_data(sdo)
    );
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        tcnt <= (tcnt == 6'(TP - 1)) ? 6'h00 : tcnt + 6'h01;
        tick <= (tcnt == 6'(TP - 1));
        stb_n <= stb_n + int'(stb);
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] c, input logic [7:0] d);
        host.wr(c, d, CHIP);
    endtask
    function automatic logic [7:0] val(input int n);
        return {2'h0, ~n[1:0], 2'h0, n[3:2] + 2'h1};
    endfunction
    function automatic shra_evt_t evt_of(input int i);
        return (i == 0 || i == 4) ? '0 : shra_evt_t'(6'h01 << (i < 4 ? i - 1 : i - 2));
    endfunction
    // Flag word with the two live pin bits folded in
    function automatic logic [15:0] ea_exp(input logic [7:0] latched);
        return {latched | {3'h0, aud_pin, 3'h0, err_pin}, 8'h00};
    endfunction
    // Fires source i, or every other non-pin source when others is set
    task automatic fire(input int i, input logic others);
        @(posedge clk);
        if (others) begin
            events <= ~evt_of(i);
        end else begin
            events <= evt_of(i);
            if (i == 0) err_pin <= ~err_pin;
            if (i == 4) aud_pin <= ~aud_pin;
        end
        @(posedge clk);
        events <= '0;
        cyc(4);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk(alert_n, 1'b1);
        chk(oe_n, 1'b1);
        for (int n = 0; n < NUM_CMD; n++) begin
            chk(cfg[n], CFG_RESET);
        end
    endtask
    task automatic t_writes;
        logic [15:0] r;
        for (int n = 1; n < NUM_CMD; n++) begin
            wr(4'(n), val(n));
        end
        for (int n = 1; n < NUM_CMD; n++) begin
            chk(cfg[n], val(n));
        end
        host.wr(CMD_OUT_FMT, 8'h33, ~CHIP);
        chk(cfg[CMD_OUT_FMT], val(7));
        host.xfer(BA_CS_WR, 16'h963c, r);
        chk(cs_byte, 8'h96);
        chk(cfg[CMD_ROUTING], val(6));
        host.xfer(8'he7, {8'h55, CMD_ROUTING, 2'h0, CHIP}, r);
        chk(cfg[CMD_ROUTING], val(6));
        chk(r, 16'hzzzz);
        chk(16'(stb_n), 16'h0002);
    endtask
    task automatic t_sources;
        logic [15:0] r;
        wr(CMD_MCLK, 8'h40);
        for (int i = 0; i < 8; i++) begin
            wr(CMD_ALERT_EN, 8'h01 << i);
            fire(i, 1'b1);
            chk(alert_n, 1'b1);
            fire(i, 1'b0);
            chk(alert_n, 1'b0);
            host.xfer(BA_INT_RD, 16'h0000, r);
            chk(r, ea_exp((8'h01 << i) & 8'hee));
            chk(alert_n, 1'b1);
            chk(rd_sel, RSEL_INT);
        end
    endtask
    task automatic t_pulse;
        logic [15:0] r;
        int          n;
        wr(CMD_GLOBAL, 8'h08);
        wr(CMD_ALERT_EN, 8'h04);
        fire(2, 1'b0);
        n = 0;
        while (alert_n === 1'b0 && n < 4 * TP) begin
            cyc(1);
            n++;
        end
        chk(n >= TP - 4 && n <= 2 * TP, 1'b1);
        host.xfer(BA_INT_RD, 16'h0000, r);
        chk(r, ea_exp(8'h04));
        wr(CMD_GLOBAL, 8'h00);
    endtask
    task automatic t_misc;
        logic [15:0] r;
        wr(CMD_GLOBAL, 8'h02);
        host.xfer(BA_INT_RD, 16'h0000, r);
        chk(r, 16'hzzzz);
        wr(CMD_ALERT_EN, 8'h80);
        fire(7, 1'b0);
        wr(CMD_GLOBAL, 8'h01);
        chk(alert_n, 1'b1);
        chk(cfg[CMD_ALERT_EN], 8'h80);
        wr(CMD_GLOBAL, 8'h00);
        host.xfer(BA_INT_RD, 16'h0000, r);
        chk(r, ea_exp(8'h00));
    endtask
    task automatic t_reads;
        logic [15:0] r;
        host.idle_hi = 1'b1;
        for (int a = 1; a < 4; a++) begin
            @(posedge clk);
            rd_word <= 16'h5a3c ^ 16'(a * 16'h0101);
            host.xfer(BA_INT_RD + 8'(a), 16'h0000, r);
            chk(r, 16'h5a3c ^ 16'(a * 16'h0101));
            chk(rd_sel, 16'(a));
        end
        wr(CMD_TX_DATA, 8'h15);
        chk(cfg[CMD_TX_DATA], 8'h15);
        host.idle_hi = 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        cyc(4);
        t_reset();
        t_writes();
        t_sources();
        t_pulse();
        t_misc();
        t_reads();
        results();
    end
    initial begin
        #400000;
        err_total++;
        results();
    end
endmodule
`default_nettype wire
